// >>> design/alu_pkg.sv
// Purpose: Shared constants and operation codes for the accumulator datapath.
// Assumes: Decode outside this block supplies one operation code per cycle.
// Notes: Flag positions are the bit indices within the flags output bus.
package alu_pkg;
	localparam int DATA_W = 8;
	localparam int FLAG_W = 6;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
	localparam int MSB = 7;
	localparam int NIB_HI = 4;
	localparam int NIB_LO = 3;
	// Flag bit positions.
	localparam int F_C = 0;
	localparam int F_AC = 1;
	localparam int F_Z = 2;
	localparam int F_OV = 3;
	localparam int F_SC = 4;
	localparam int F_CZ = 5;

	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_ROTL_CARRY_TO_ACC = 5'h01,
		OP_ROTR_MEM = 5'h02,
		OP_ROTR_TO_ACC = 5'h03,
		OP_ROTR_CARRY_MEM = 5'h04,
		OP_ROTR_CARRY_TO_ACC = 5'h05,
		OP_SUB_WITH_BORROW = 5'h06,
		OP_SUB_WITH_BORROW_IMM = 5'h07,
		OP_SUB_WITH_BORROW_TO_MEM = 5'h08,
		OP_SUB = 5'h09,
		OP_PLAIN_SUBTRACT_TO_MEM = 5'h0a,
		OP_SUB_IMM = 5'h0b,
		OP_DEC_SKIP_ZERO = 5'h0c,
		OP_DEC_SKIP_ZERO_TO_ACC = 5'h0d,
		OP_SET_BYTE = 5'h0e,
		OP_SET_BIT = 5'h0f,
		OP_INC_SKIP_ZERO = 5'h10,
		OP_INC_SKIP_ZERO_TO_ACC = 5'h11,
		OP_SKIP_IF_BIT_SET = 5'h12,
		OP_SKIP_IF_NONZERO = 5'h13,
		OP_NIBBLE_EXCHANGE = 5'h14,
		OP_NIBBLE_EXCHANGE_TO_ACC = 5'h15,
		OP_SKIP_IF_ZERO = 5'h16,
		OP_SKIP_IF_ZERO_COPY_ACC = 5'h17
	} alu_op_t;

	typedef enum logic [0:0] {
		ST_EXEC = 1'b0,
		ST_DUMMY = 1'b1
	} phase_t;
endpackage

// >>> design/rotate_sub_skip_alu.sv
// Purpose: Accumulator datapath for rotate, subtract, set, swap and skip.
// Assumes: mem_rd_data holds the addressed byte in the cycle of op_valid.
// Notes: A skip adds one dummy cycle, during which busy is high.
`timescale 1ns/1ns
module rotate_sub_skip_alu
	import alu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic op_valid,
	input wire alu_op_t op_code,
	input wire logic [2:0] bit_sel,
	input wire logic [DATA_W-1:0] imm_data,
	input wire logic [DATA_W-1:0] mem_rd_data,
	output logic busy,
	output logic [DATA_W-1:0] mem_wr_data,
	output logic mem_wr_en,
	output logic skip_next,
	output logic [DATA_W-1:0] accumulator,
	output logic [FLAG_W-1:0] flags
);

	typedef struct packed {
		phase_t phase;
		logic [DATA_W-1:0] acc;
		logic [FLAG_W-1:0] flg;
		logic [DATA_W-1:0] wdata;
		logic wen;
		logic skip;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Subtract a - b - borrow; returns {carry, aux, ov, result}.
	function automatic logic [DATA_W+2:0] subtract(
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b,
		input logic borrow
	);
		logic [DATA_W:0] full;
		logic [NIB_HI:0] low;
		logic ov;
		full = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, borrow};
		low = {1'b0, a[NIB_LO:0]} - {1'b0, b[NIB_LO:0]}
			- {{NIB_HI{1'b0}}, borrow};
		ov = (a[MSB] != b[MSB]) && (full[MSB] != a[MSB]);
		// Carry is the inverted borrow out of bit 7.
		subtract = {~full[DATA_W], ~low[NIB_HI], ov, full[DATA_W-1:0]};
	endfunction

	// Decode of operations whose result lands in the accumulator.
	function automatic logic to_acc(input alu_op_t op);
		unique case (op)
			OP_ROTL_CARRY_TO_ACC, OP_ROTR_TO_ACC, OP_ROTR_CARRY_TO_ACC,
			OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_IMM, OP_SUB, OP_SUB_IMM,
			OP_DEC_SKIP_ZERO_TO_ACC, OP_INC_SKIP_ZERO_TO_ACC,
			OP_NIBBLE_EXCHANGE_TO_ACC, OP_SKIP_IF_ZERO_COPY_ACC:
				to_acc = 1'b1;
			default: to_acc = 1'b0;
		endcase
	endfunction

	// Decode of subtract operations, which all touch the flag set.
	function automatic logic is_sub(input alu_op_t op);
		unique case (op)
			OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_IMM,
			OP_SUB_WITH_BORROW_TO_MEM, OP_SUB, OP_PLAIN_SUBTRACT_TO_MEM,
			OP_SUB_IMM:
				is_sub = 1'b1;
			default: is_sub = 1'b0;
		endcase
	endfunction

	// Next-state logic: one executing cycle, plus a dummy cycle on skip.
	always_comb begin
		logic [DATA_W-1:0] res;
		logic [DATA_W-1:0] sub_b;
		logic [DATA_W+2:0] sr;
		logic carry_in;
		logic use_borrow;
		logic do_skip;
		logic mem_out;
		logic new_c;
		logic wr_c;
		res = ZERO_BYTE;
		sub_b = mem_rd_data;
		sr = '0;
		carry_in = s_q.flg[F_C];
		use_borrow = 1'b0;
		do_skip = 1'b0;
		mem_out = 1'b0;
		new_c = carry_in;
		wr_c = 1'b0;
		s_d = s_q;
		s_d.wen = 1'b0;
		s_d.skip = 1'b0;
		if (s_q.phase == ST_DUMMY) begin
			// The dummy cycle ignores the slot of the skipped instruction.
			s_d.phase = ST_EXEC;
		end else if (op_valid) begin
			unique case (op_code)
				OP_ROTL_CARRY_TO_ACC: begin
					res = {mem_rd_data[MSB-1:0], carry_in};
					new_c = mem_rd_data[MSB];
					wr_c = 1'b1;
				end
				OP_ROTR_MEM: begin
					res = {mem_rd_data[0], mem_rd_data[MSB:1]};
					mem_out = 1'b1;
				end
				OP_ROTR_TO_ACC: begin
					res = {mem_rd_data[0], mem_rd_data[MSB:1]};
				end
				OP_ROTR_CARRY_MEM: begin
					res = {carry_in, mem_rd_data[MSB:1]};
					new_c = mem_rd_data[0];
					wr_c = 1'b1;
					mem_out = 1'b1;
				end
				OP_ROTR_CARRY_TO_ACC: begin
					res = {carry_in, mem_rd_data[MSB:1]};
					new_c = mem_rd_data[0];
					wr_c = 1'b1;
				end
				OP_SUB_WITH_BORROW: use_borrow = 1'b1;
				OP_SUB_WITH_BORROW_IMM: begin
					use_borrow = 1'b1;
					sub_b = imm_data;
				end
				OP_SUB_WITH_BORROW_TO_MEM: begin
					use_borrow = 1'b1;
					mem_out = 1'b1;
				end
				OP_SUB: use_borrow = 1'b0;
				OP_PLAIN_SUBTRACT_TO_MEM: mem_out = 1'b1;
				OP_SUB_IMM: sub_b = imm_data;
				OP_DEC_SKIP_ZERO: begin
					res = mem_rd_data - ONE_BYTE;
					mem_out = 1'b1;
					do_skip = (res == ZERO_BYTE);
				end
				OP_DEC_SKIP_ZERO_TO_ACC: begin
					res = mem_rd_data - ONE_BYTE;
					do_skip = (res == ZERO_BYTE);
				end
				OP_SET_BYTE: begin
					res = ALL_ONES;
					mem_out = 1'b1;
				end
				OP_SET_BIT: begin
					res = mem_rd_data | (ONE_BYTE << bit_sel);
					mem_out = 1'b1;
				end
				OP_INC_SKIP_ZERO: begin
					res = mem_rd_data + ONE_BYTE;
					mem_out = 1'b1;
					do_skip = (res == ZERO_BYTE);
				end
				OP_INC_SKIP_ZERO_TO_ACC: begin
					res = mem_rd_data + ONE_BYTE;
					do_skip = (res == ZERO_BYTE);
				end
				OP_SKIP_IF_BIT_SET: begin
					do_skip = mem_rd_data[bit_sel];
				end
				OP_SKIP_IF_NONZERO: begin
					do_skip = (mem_rd_data != ZERO_BYTE);
				end
				OP_NIBBLE_EXCHANGE: begin
					res = {mem_rd_data[NIB_LO:0],
						mem_rd_data[MSB:NIB_HI]};
					mem_out = 1'b1;
				end
				OP_NIBBLE_EXCHANGE_TO_ACC: begin
					res = {mem_rd_data[NIB_LO:0],
						mem_rd_data[MSB:NIB_HI]};
				end
				OP_SKIP_IF_ZERO: begin
					do_skip = (mem_rd_data == ZERO_BYTE);
				end
				OP_SKIP_IF_ZERO_COPY_ACC: begin
					res = mem_rd_data;
					do_skip = (mem_rd_data == ZERO_BYTE);
				end
				default: res = ZERO_BYTE;
			endcase
			// Shared subtractor; in the borrow forms the borrow is the inverted incoming carry.
			sr = subtract(s_q.acc, sub_b, use_borrow & ~carry_in);
			if (is_sub(op_code)) begin
				res = sr[DATA_W-1:0];
				s_d.flg[F_C] = sr[DATA_W+2];
				s_d.flg[F_AC] = sr[DATA_W+1];
				s_d.flg[F_OV] = sr[DATA_W];
				s_d.flg[F_Z] = (res == ZERO_BYTE);
				// Signed compare is the result sign bit XOR overflow, true when a is below b signed.
				s_d.flg[F_SC] = sr[DATA_W] ^ res[MSB];
				// Chained zero only stays set when the borrow forms chain it.
				s_d.flg[F_CZ] = use_borrow ?
					(s_q.flg[F_CZ] & (res == ZERO_BYTE)) :
					(res == ZERO_BYTE);
			end else if (wr_c) begin
				s_d.flg[F_C] = new_c;
			end
			if (to_acc(op_code)) begin
				s_d.acc = res;
			end
			if (mem_out) begin
				s_d.wen = 1'b1;
				s_d.wdata = res;
			end
			if (do_skip) begin
				// The skipped slot becomes a dummy cycle.
				s_d.skip = 1'b1;
				s_d.phase = ST_DUMMY;
			end
		end
	end

	// State register; reset gives a cleared accumulator and flags.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{phase: ST_EXEC, acc: ACC_RESET, flg: FLAGS_RESET,
				wdata: ZERO_BYTE, wen: 1'b0, skip: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register.
	assign busy = (s_q.phase == ST_DUMMY);
	assign mem_wr_data = s_q.wdata;
	assign mem_wr_en = s_q.wen;
	assign skip_next = s_q.skip;
	assign accumulator = s_q.acc;
	assign flags = s_q.flg;

endmodule

// >>> tb/rotate_sub_skip_alu_chk.sv
// Purpose: Port checks for the rotate, subtract and skip datapath.
// Assumes: An op is taken with op_valid high and busy low.
// Notes: Results are judged one cycle after the op is taken.
`timescale 1ns/1ns
module rotate_sub_skip_alu_chk
	import alu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic op_valid,
	input wire alu_op_t op_code,
	input wire logic [2:0] bit_sel,
	input wire logic [DATA_W-1:0] imm_data,
	input wire logic [DATA_W-1:0] mem_rd_data,
	input wire logic busy,
	input wire logic [DATA_W-1:0] mem_wr_data,
	input wire logic mem_wr_en,
	input wire logic skip_next,
	input wire logic [DATA_W-1:0] accumulator,
	input wire logic [FLAG_W-1:0] flags
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// The dummy cycle refuses ops, so an op only counts outside it.
	wire t = op_valid && !busy;
	wire [7:0] m = mem_rd_data;
	wire cy = flags[F_C];
	a_rotl_to_acc:
	assert property (t && op_code == OP_ROTL_CARRY_TO_ACC |=> accumulator ==
		{$past(m[6:0]), $past(cy)} && cy == $past(m[7])) else $error("rotl");
	a_rotr_mem:
	assert property (t && op_code == OP_ROTR_MEM |=> mem_wr_en &&
		mem_wr_data == {$past(m[0]), $past(m[7:1])} && $stable(flags))
		else $error("rotr mem");
	a_rotr_carry:
	assert property (t && op_code == OP_ROTR_CARRY_MEM |=> mem_wr_en &&
		mem_wr_data == {$past(cy), $past(m[7:1])} && cy == $past(m[0]))
		else $error("rotr carry");
	a_sub_borrow:
	assert property (t && op_code == OP_SUB_WITH_BORROW |=> accumulator ==
		$past(accumulator) - $past(m) - !$past(cy)) else $error("sbc");
	a_sub_carry:
	assert property (t && op_code == OP_SUB |=> accumulator ==
		$past(accumulator) - $past(m) &&
		cy == ($past(accumulator) >= $past(m))) else $error("sub");
	a_dec_skip:
	assert property (t && op_code == OP_DEC_SKIP_ZERO |=> mem_wr_en &&
		mem_wr_data == $past(m) - 8'h01 && skip_next == ($past(m) == 8'h01))
		else $error("dec skip");
	a_nonzero_skip:
	assert property (t && op_code == OP_SKIP_IF_NONZERO |=> !mem_wr_en &&
		skip_next == ($past(m) != 8'h00)) else $error("nonzero skip");
	a_dead_slot:
	assert property (skip_next |-> busy ##1 !busy && !mem_wr_en)
		else $error("dead slot");
	c_skip: cover property (skip_next);
	c_borrow: cover property (t && op_code == OP_SUB_WITH_BORROW);
	c_refused: cover property (busy && op_valid);
endmodule

bind rotate_sub_skip_alu rotate_sub_skip_alu_chk i_chk(.*);

// >>> tb/mcu_rotate_sub_skip_alu_tb_top.sv
// Purpose: Directed checks of the rotate, subtract, set and skip ops.
// Assumes: Results stand one cycle after an op is taken.
// Notes: Scenarios run in order; the carry chains from one to the next.
`timescale 1ns/1ns
module mcu_rotate_sub_skip_alu_tb_top;
	import alu_pkg::*;
	logic ref_clk = 1'h0, rst_b = 1'h0, op_valid = 1'h0;
	alu_op_t op_code = OP_NONE;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] imm_data = 8'h00, mem_rd_data = 8'h00;
	logic [7:0] mem_wr_data, accumulator;
	logic busy, mem_wr_en, skip_next;
	logic [5:0] flags;
	int failures = 0, tests_run = 0;
	rotate_sub_skip_alu i_dut(.*);
	// Free-running core clock.
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Compares one value and counts it.
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	// One op for one cycle; f is carry, write and skip. The immediate and
	// bit index derive from the memory byte, so a wrong source shows.
	task automatic run(alu_op_t o, logic [7:0] m, ex, logic [2:0] f);
		@(posedge ref_clk);
		op_valid <= 1'h1;
		op_code <= o;
		mem_rd_data <= m;
		imm_data <= ~m;
		bit_sel <= m[6:4];
		@(posedge ref_clk);
		op_valid <= 1'h0;
		#1;
		chk({flags[F_C], mem_wr_en, skip_next, busy}, {f, f[0]});
		chk(f[1] ? mem_wr_data : accumulator, ex);
	endtask
	// Rotates; zero minus zero first leaves the carry set.
	task automatic t_rotate;
		run(OP_SUB, 8'h00, 8'h00, 3'h4);
		// A zero difference sets Z and CZ; no nibble borrow sets AC.
		chk(flags, 8'h27);
		run(OP_ROTR_CARRY_MEM, 8'h02, 8'h81, 3'h2);
		run(OP_ROTL_CARRY_TO_ACC, 8'h81, 8'h02, 3'h4);
		run(OP_ROTR_CARRY_TO_ACC, 8'h00, 8'h80, 3'h0);
		run(OP_ROTR_TO_ACC, 8'h03, 8'h81, 3'h0);
		run(OP_ROTR_MEM, 8'h01, 8'h80, 3'h2);
	endtask
	// Subtracts with both carry levels, including signed overflow.
	task automatic t_subtract;
		run(OP_SUB_WITH_BORROW, 8'h02, 8'h7e, 3'h4);
		chk(flags[F_OV], 1'h1);
		// Overflow with a positive result makes SC true; CZ chains low.
		chk(flags, 8'h19);
		run(OP_SUB_IMM, 8'h7f, 8'hfe, 3'h0);
		chk(flags, 8'h0a);
		run(OP_PLAIN_SUBTRACT_TO_MEM, 8'h0e, 8'hf0, 3'h6);
		run(OP_SUB_WITH_BORROW_IMM, 8'hf0, 8'hef, 3'h4);
		run(OP_SUB_WITH_BORROW_TO_MEM, 8'hee, 8'h01, 3'h6);
		chk(accumulator, 8'hef);
		chk(flags, 8'h03);
	endtask
	// Skips, taken and not taken; carry must stay set throughout.
	task automatic t_skip;
		run(OP_DEC_SKIP_ZERO, 8'h01, 8'h00, 3'h7);
		run(OP_DEC_SKIP_ZERO_TO_ACC, 8'h01, 8'h00, 3'h5);
		run(OP_INC_SKIP_ZERO_TO_ACC, 8'h7f, 8'h80, 3'h4);
		run(OP_SKIP_IF_ZERO_COPY_ACC, 8'h00, 8'h00, 3'h5);
		run(OP_INC_SKIP_ZERO, 8'hff, 8'h00, 3'h7);
		run(OP_SKIP_IF_BIT_SET, 8'h60, 8'h00, 3'h5);
		run(OP_SKIP_IF_NONZERO, 8'h00, 8'h00, 3'h4);
		run(OP_SKIP_IF_ZERO, 8'h00, 8'h00, 3'h5);
	endtask
	// Set and nibble exchange.
	task automatic t_set;
		run(OP_SET_BYTE, 8'h12, 8'hff, 3'h6);
		run(OP_SET_BIT, 8'h70, 8'hf0, 3'h6);
		run(OP_NIBBLE_EXCHANGE, 8'h12, 8'h21, 3'h6);
		run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'ha5, 8'h5a, 3'h4);
	endtask
	// An op held into the dummy cycle must be dropped.
	task automatic t_refused;
		run(OP_DEC_SKIP_ZERO, 8'h01, 8'h00, 3'h7);
		op_valid <= 1'h1;
		@(posedge ref_clk);
		op_valid <= 1'h0;
		#1;
		chk({mem_wr_en, busy}, 2'h0);
	endtask
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Reset for eight cycles, then the scenarios in order.
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'h1;
		t_rotate();
		t_subtract();
		t_skip();
		t_set();
		t_refused();
		wrap_up();
	end
	// About 60 cycles are needed; a hang is cut well after that.
	initial begin
		#5000;
		failures++;
		wrap_up();
	end
endmodule
